// >>> hw/ssl_pkg.sv
// Purpose: constants and types for the supply supervision logic
// Assumes: 40 MHz sys_clk, APB register access
// Notes: times kept in ns, cycle counts derived from them
package ssl_pkg;
    localparam int CLK_NS = 25;
    localparam int COOL_NS = 1_000_000_000;
    localparam int MAIN_START_NS = 4_000_000;
    localparam int MAIN_DIP_NS = 5_000;
    localparam int RESET_FILT_NS = 16_000;
    localparam int AUX_DIP_NS = 2_000;
    localparam int AUX_SHORT_NS = 4_000_000;
    // least times, rounded up to whole cycles
    localparam int COOL_CYC = (COOL_NS + CLK_NS - 1) / CLK_NS;
    localparam int MAIN_START_CYC = (MAIN_START_NS + CLK_NS - 1) / CLK_NS;
    localparam int MAIN_DIP_CYC = (MAIN_DIP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_FILT_CYC = (RESET_FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int AUX_DIP_CYC = (AUX_DIP_NS + CLK_NS - 1) / CLK_NS;
    localparam int AUX_SHORT_CYC = (AUX_SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int THERM_REPEAT = 3;
    // register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [2:0] CTRL_RST = 3'h0;
    // status bit positions
    localparam int ST_MAIN_FAIL = 0;
    localparam int ST_AUX_FAIL = 1;
    localparam int ST_AUX_SHORT = 2;
    localparam int ST_THERM = 3;
    localparam int ST_XCVR_LAT = 4;
    localparam int ST_XCVR_NOW = 5;
    localparam int ST_HOST_RST = 6;
    localparam int ST_WDOG = 7;
    // analog comparator outputs, all asynchronous to sys_clk
    typedef struct packed {
        logic mainAboveFail;
        logic mainAboveReset;
        logic auxAboveFail;
        logic xcvrSupplyLow;
        logic thermalWarn;
        logic thermalShut;
        logic loadCurrentLow;
        logic loadCurrentHigh;
    } ssl_cmp_t;
    typedef enum logic [3:0] {
        MS_START = 4'b0001,
        MS_RUN = 4'b0010,
        MS_COOL = 4'b0100,
        MS_SLEEP = 4'b1000
    } ssl_main_t;
endpackage

// >>> hw/supply_supervision_logic.sv
// Purpose: supervision of main and aux regulators and transceiver supply
// Assumes: comparator outputs asynchronous, mode inputs on sys_clk
// Notes: one clock, APB slave with zero wait states
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module ssl_filter #(
    parameter int CYC = 2
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic bad,
    output logic expired
);
    localparam int W = $clog2(CYC + 1);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    assign expired = (cnt_ff == CYC[W-1:0]);
    // restart on healthy input, hold at expiry
    assign nxt_cnt = !bad ? '0 : (expired ? cnt_ff : cnt_ff + 1'b1);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) cnt_ff <= '0;
        else cnt_ff <= nxt_cnt;
    end
endmodule

module supply_supervision_logic
    import ssl_pkg::*;
#(
    parameter int COOL_CYCLES = COOL_CYC,
    parameter int START_CYCLES = MAIN_START_CYC,
    parameter int SHORT_CYCLES = AUX_SHORT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ssl_cmp_t cmpIn,
    input wire logic modeNormal,
    input wire logic modeStandby,
    input wire logic cyclicSense,
    input wire logic wakeUp,
    input wire logic watchdogServed,
    input wire logic xcvrEnableReq,
    output logic mainRegEn,
    output logic auxRegEn,
    output logic loadDriversEn,
    output logic forceSleep,
    output logic hostResetN,
    output logic watchdogEn,
    output logic xcvrEn,
    output logic [1:0] resetThreshold
);
    ssl_cmp_t cmpMeta_ff, cmp_ff;
    ssl_main_t state_ff, nxt_state;
    logic [3:0] shutCnt_ff;
    logic [2:0] ctrl_ff;
    logic [31:0] rdata_ff;
    logic mainFail_ff, auxFail_ff, auxShort_ff, therm_ff, xcvrLat_ff;
    logic hostRst_ff, blocked_ff, auxLock_ff, wdEn_ff;
    logic coolExp, startExp, mainDipExp, resetExp, auxDipExp, auxShortExp;

    // two-stage synchroniser on every comparator
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmpMeta_ff <= '0;
            cmp_ff <= '0;
        end else begin
            cmpMeta_ff <= cmpIn;
            cmp_ff <= cmpMeta_ff;
        end
    end

    // apb decode, no wait states
    wire setupRd = psel && !penable && !pwrite;
    wire access = psel && penable;
    wire hitCtrl = (paddr == CTRL_OFS);
    wire hitStatus = (paddr == STATUS_OFS);
    wire ctrlWr = access && pwrite && hitCtrl;
    wire statusClr = access && !pwrite && hitStatus;
    assign pready = 1'b1;
    assign pslverr = access && !(hitCtrl || hitStatus);
    assign prdata = rdata_ff;

    // main regulator state
    wire inStart = (state_ff == MS_START);
    wire inRun = (state_ff == MS_RUN);
    wire inCool = (state_ff == MS_COOL);
    wire inSleep = (state_ff == MS_SLEEP);
    wire shutEvent = (inStart || inRun) && cmp_ff.thermalShut;
    wire repeated = (shutCnt_ff >= THERM_REPEAT[3:0]);

    ssl_filter #(.CYC(COOL_CYCLES)) uCool (
        .sys_clk(sys_clk), .rst_b(rst_b), .bad(inCool), .expired(coolExp)
    );
    ssl_filter #(.CYC(START_CYCLES)) uStart (
        .sys_clk(sys_clk), .rst_b(rst_b),
        .bad(inStart && !cmp_ff.mainAboveFail), .expired(startExp)
    );
    ssl_filter #(.CYC(MAIN_DIP_CYC)) uMainDip (
        .sys_clk(sys_clk), .rst_b(rst_b),
        .bad(inRun && !cmp_ff.mainAboveFail), .expired(mainDipExp)
    );
    ssl_filter #(.CYC(RESET_FILT_CYC)) uReset (
        .sys_clk(sys_clk), .rst_b(rst_b),
        .bad(!cmp_ff.mainAboveReset), .expired(resetExp)
    );

    // next state of the main regulator sequence
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            MS_START: begin
                if (cmp_ff.thermalShut) nxt_state = MS_COOL;
                else if (startExp) nxt_state = MS_SLEEP;
                else if (cmp_ff.mainAboveFail) nxt_state = MS_RUN;
            end
            MS_RUN: begin
                if (cmp_ff.thermalShut) nxt_state = MS_COOL;
            end
            MS_COOL: begin
                // too many cool-downs since the last wake means sleep until wakeUp
                if (coolExp) nxt_state = repeated ? MS_SLEEP : MS_START;
            end
            MS_SLEEP: begin
                if (wakeUp) nxt_state = MS_START;
            end
            default: nxt_state = MS_START;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) state_ff <= MS_START;
        else state_ff <= nxt_state;
    end

    // count second-level shutdowns, cleared by a wake from sleep
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) shutCnt_ff <= '0;
        else if (inSleep && wakeUp) shutCnt_ff <= '0;
        else if (shutEvent && !repeated) shutCnt_ff <= shutCnt_ff + 1'b1;
    end

    // aux monitoring in normal and cyclic-sense modes only
    wire auxMon = modeNormal || cyclicSense;
    wire auxOn = ctrl_ff[2] && !auxLock_ff && !blocked_ff && !therm_ff;
    ssl_filter #(.CYC(AUX_DIP_CYC)) uAuxDip (
        .sys_clk(sys_clk), .rst_b(rst_b),
        .bad(auxMon && auxOn && !cmp_ff.auxAboveFail), .expired(auxDipExp)
    );
    // same counter covers slow start-up and a lasting dip
    ssl_filter #(.CYC(SHORT_CYCLES)) uAuxShort (
        .sys_clk(sys_clk), .rst_b(rst_b),
        .bad(auxMon && auxOn && !cmp_ff.auxAboveFail), .expired(auxShortExp)
    );

    // latched flags: event wins over same-cycle read-and-clear
    wire mainFailSet = (inStart && startExp) || mainDipExp;
    wire xcvrLow = cmp_ff.xcvrSupplyLow;
    wire xcvrLatSet = xcvrEnableReq && xcvrLow;
    // clear only what the last status read reported, so an event landing
    // between the setup and access edges is not lost unseen
    wire [31:0] clrMask = statusClr ? rdata_ff : 32'h0;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mainFail_ff <= 1'b0;
            auxFail_ff <= 1'b0;
            auxShort_ff <= 1'b0;
            therm_ff <= 1'b0;
            xcvrLat_ff <= 1'b0;
        end else begin
            mainFail_ff <= mainFailSet
                || (mainFail_ff && !clrMask[ST_MAIN_FAIL]);
            auxFail_ff <= auxDipExp || auxShortExp
                || (auxFail_ff && !clrMask[ST_AUX_FAIL]);
            auxShort_ff <= auxShortExp || (auxShort_ff && !clrMask[ST_AUX_SHORT]);
            therm_ff <= cmp_ff.thermalWarn || (therm_ff && !clrMask[ST_THERM]);
            xcvrLat_ff <= xcvrLatSet || (xcvrLat_ff && !clrMask[ST_XCVR_LAT]);
        end
    end

    // aux lock released only once both flags read clear; ctrl bit untouched
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) auxLock_ff <= 1'b0;
        else if (auxShortExp) auxLock_ff <= 1'b1;
        else if (!auxFail_ff && !auxShort_ff) auxLock_ff <= 1'b0;
    end

    // host reset and output blocking until watchdog served
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hostRst_ff <= 1'b0;
            blocked_ff <= 1'b0;
        end else begin
            if (resetExp) hostRst_ff <= 1'b1;
            else if (cmp_ff.mainAboveReset) hostRst_ff <= 1'b0;
            if (resetExp) blocked_ff <= 1'b1;
            else if (!hostRst_ff && watchdogServed) blocked_ff <= 1'b0;
        end
    end

    // watchdog gating in standby by load current, hysteresis via two levels
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) wdEn_ff <= 1'b1;
        else if (!modeStandby) wdEn_ff <= 1'b1;
        else if (cmp_ff.loadCurrentHigh) wdEn_ff <= 1'b1;
        else if (cmp_ff.loadCurrentLow) wdEn_ff <= 1'b0;
    end

    // software control register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) ctrl_ff <= CTRL_RST;
        else if (ctrlWr) ctrl_ff <= pwdata[2:0];
    end

    // live status view, read data captured in setup cycle
    logic [31:0] statusWord;
    always_comb begin
        statusWord = '0;
        statusWord[ST_MAIN_FAIL] = mainFail_ff;
        statusWord[ST_AUX_FAIL] = auxFail_ff;
        statusWord[ST_AUX_SHORT] = auxShort_ff;
        statusWord[ST_THERM] = therm_ff;
        statusWord[ST_XCVR_LAT] = xcvrLat_ff;
        statusWord[ST_XCVR_NOW] = modeNormal && xcvrLow;
        statusWord[ST_HOST_RST] = hostRst_ff;
        statusWord[ST_WDOG] = wdEn_ff;
    end
    wire [31:0] rdMux = hitCtrl ? {29'h0, ctrl_ff} : (hitStatus ? statusWord : 32'h0);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) rdata_ff <= 32'h0;
        else if (setupRd) rdata_ff <= rdMux;
    end

    // outputs
    assign mainRegEn = inStart || inRun;
    assign forceSleep = inSleep;
    assign hostResetN = !hostRst_ff;
    assign loadDriversEn = !blocked_ff && !therm_ff;
    assign auxRegEn = auxOn;
    assign watchdogEn = wdEn_ff;
    assign xcvrEn = xcvrEnableReq && !xcvrLow;
    assign resetThreshold = ctrl_ff[1:0];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    AST_COOL: assert property (inRun && cmp_ff.thermalShut |=> inCool && !mainRegEn)
        else $error("thermal shutdown did not stop main regulator");
    AST_REPEAT: assert property (inCool && coolExp && repeated |=> forceSleep)
        else $error("repeated thermal shutdown did not force sleep");
    AST_START: assert property (inStart && startExp && !cmp_ff.thermalShut
        |=> forceSleep && mainFail_ff)
        else $error("main start-up timeout not handled");
    AST_DIP: assert property ($rose(mainDipExp) |=> mainFail_ff)
        else $error("main dip not latched");
    AST_RST: assert property (resetExp |=> !hostResetN ##0 !loadDriversEn)
        else $error("reset filter expiry did not drive reset");
    AST_BLOCK: assert property (!hostResetN |-> !auxRegEn && !loadDriversEn)
        else $error("outputs on during host reset");
    AST_WDOFF: assert property (modeStandby && cmp_ff.loadCurrentLow && !cmp_ff.loadCurrentHigh
        ##1 modeStandby |-> !watchdogEn)
        else $error("watchdog not disabled at low load");
    AST_WDON: assert property (modeStandby && cmp_ff.loadCurrentHigh |=> watchdogEn)
        else $error("watchdog not enabled at high load");
    AST_THERM: assert property (cmp_ff.thermalWarn |=> therm_ff && !loadDriversEn && !auxRegEn)
        else $error("first thermal level not handled");
    AST_AUXSHORT: assert property (auxShortExp |=> !auxRegEn && auxShort_ff && auxFail_ff)
        else $error("aux short not handled");
    AST_LOCK: assert property (auxShort_ff |-> !auxRegEn)
        else $error("aux re-enabled before flags cleared");
    AST_XCVR: assert property (xcvrLow |-> !xcvrEn)
        else $error("transceiver enabled under low supply");
    AST_SETWIN: assert property (xcvrLatSet && statusClr |=> xcvrLat_ff)
        else $error("clear beat a same-cycle event");
    // further guards on flags, sequencing and the reset path
    AST_MAINSET: assert property (mainFailSet |=> mainFail_ff)
        else $error("main failure not latched");
    AST_CLR: assert property (statusClr && rdata_ff[ST_MAIN_FAIL] && !mainFailSet
        |=> !mainFail_ff)
        else $error("reported main failure not cleared");
    AST_AUXDIP: assert property (auxDipExp |=> auxFail_ff)
        else $error("aux dip not latched");
    AST_AUXSTAY: assert property (auxDipExp && !auxShortExp && auxRegEn && !ctrlWr
        && !resetExp && !cmp_ff.thermalWarn |=> auxRegEn)
        else $error("aux regulator dropped on a transient dip");
    AST_XLAT: assert property (xcvrLatSet |=> xcvrLat_ff)
        else $error("transceiver supply low not latched");
    AST_XHOLD: assert property (xcvrLat_ff && !statusClr |=> xcvrLat_ff)
        else $error("transceiver flag lost without a clear");
    AST_UNBLOCK: assert property ($fell(blocked_ff)
        |-> $past(watchdogServed) && hostResetN)
        else $error("outputs released without reset high and watchdog served");
    AST_SLEEPSTAY: assert property (forceSleep && !wakeUp |=> forceSleep)
        else $error("forced sleep left without wake");
    AST_WDFORCE: assert property (!modeStandby |=> watchdogEn)
        else $error("watchdog off outside standby");
    AST_NORST: assert property (hostResetN && !resetExp |=> hostResetN)
        else $error("host reset without filter expiry");
    AST_CTRLKEEP: assert property (auxShortExp && !ctrlWr |=> ctrl_ff == $past(ctrl_ff))
        else $error("aux short changed control bits");
    AST_COOLSTAY: assert property (inCool && !coolExp |=> inCool && !mainRegEn)
        else $error("main regulator restarted before cool-down ended");
    AST_THERMOFF: assert property (therm_ff |-> !auxRegEn && !loadDriversEn)
        else $error("loads on while thermal flag set");
endmodule

// >>> tb/ssl_host_model.sv
// Purpose: host controller model on the reset line of the supervision logic
// Assumes: hostResetN low while the host is held in reset
// Notes: serves the watchdog once, HOLD cycles after reset lifts
`timescale 1ns/1ps
module ssl_host_model #(
    parameter int HOLD = 10
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic hostResetN,
    output logic watchdogServed
);
    logic wasReset_ff;
    logic serve_ff;
    int wait_ff;
    // boot delay after reset, then one correct service
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wasReset_ff <= 1'b0;
            serve_ff <= 1'b0;
            wait_ff <= 0;
        end else begin
            wasReset_ff <= !hostResetN;
            serve_ff <= (wait_ff == 1);
            if (!hostResetN) begin
                wait_ff <= 0;
            end else if (wasReset_ff) begin
                wait_ff <= HOLD;
            end else if (wait_ff != 0) begin
                wait_ff <= wait_ff - 1;
            end
        end
    end
    // one-cycle pulse; a real host needs time to boot first
    assign watchdogServed = serve_ff;
endmodule

// >>> tb/test_supply_supervision_logic.sv
// Purpose: self-checking bench for the supply supervision logic
// Assumes: ssl_pkg compiled first, host model serves the watchdog
// Notes: cool, start-up and aux short counts shortened by parameter
`timescale 1ns/1ps
module test_supply_supervision_logic
    import ssl_pkg::*;
;
    logic sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h7544da52;
    logic pready, pslverr, err, watchdogServed, mainRegEn, auxRegEn, loadDriversEn;
    logic forceSleep, hostResetN, watchdogEn, xcvrEn, cyclicSense = 1'b0;
    logic modeNormal = 1'b1, modeStandby = 1'b0, wakeUp = 1'b0, xcvrEnableReq = 1'b1;
    logic [1:0] resetThreshold;
    ssl_cmp_t cmpIn = 8'he0;
    int numErrors = 0, nTests = 0;
    // 40 MHz system clock
    always #12.5 sys_clk = ~sys_clk;
    // block with shortened long counts
    supply_supervision_logic #(
        .COOL_CYCLES(50),
        .START_CYCLES(40),
        .SHORT_CYCLES(120)
    ) supply_supervision_logic_inst (
        .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cmpIn, .modeNormal, .modeStandby, .cyclicSense, .wakeUp,
        .watchdogServed, .xcvrEnableReq, .mainRegEn, .auxRegEn, .loadDriversEn,
        .forceSleep, .hostResetN, .watchdogEn, .xcvrEn, .resetThreshold
    );
    // host serves the watchdog once reset lifts
    ssl_host_model #(.HOLD(10)) ssl_host_model_inst (
        .sys_clk, .rst_b, .hostResetN, .watchdogServed
    );
    task final_report;
        if (numErrors == 0 && nTests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        nTests++;
        if (s !== e) begin
            numErrors++;
            $display("unexpected at %0t: got %h expected %h", $time, s, e);
        end
    endtask
    task chkb(input logic s, input logic e);
        chk({31'h0, s}, {31'h0, e});
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // one transfer, request held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        if (n >= 50) begin
            numErrors++;
            final_report();
        end
    endtask
    // status read: f holds the six flag bits, watchdog on, no host reset
    task stchk(input logic [5:0] f);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rd, {24'h0, 2'b10, f});
    endtask
    initial begin
        cyc(5);
        rst_b <= 1'b1;
        cyc(3);
        chkb(mainRegEn, 1'b1);
        chkb(hostResetN, 1'b1);
        chkb(auxRegEn, 1'b0);
        stchk(6'h00);
        apb(1'b0, 12'h008, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            apb(1'b1, CTRL_OFS, {seed[31:3], 1'b0, 2'(i)});
            chk({30'h0, resetThreshold}, 32'(i));
            apb(1'b0, CTRL_OFS, 32'h0);
            chk(rd, 32'(i));
        end
        // two short dips with a gap must not add up
        cmpIn.mainAboveFail <= 1'b0;
        cyc(150 + int'(seed[4:0]));
        cmpIn.mainAboveFail <= 1'b1;
        cyc(3);
        cmpIn.mainAboveFail <= 1'b0;
        cyc(150);
        cmpIn.mainAboveFail <= 1'b1;
        cyc(4);
        stchk(6'h00);
        cmpIn.mainAboveFail <= 1'b0;
        cyc(215);
        cmpIn.mainAboveFail <= 1'b1;
        cyc(4);
        stchk(6'h01);
        stchk(6'h00);
        cmpIn.mainAboveReset <= 1'b0;
        cyc(600);
        chkb(hostResetN, 1'b1);
        cyc(100);
        chkb(hostResetN, 1'b0);
        chkb(loadDriversEn, 1'b0);
        cmpIn.mainAboveReset <= 1'b1;
        cyc(5);
        chkb(hostResetN, 1'b1);
        chkb(loadDriversEn, 1'b0);
        cyc(20);
        chkb(loadDriversEn, 1'b1);
        apb(1'b1, CTRL_OFS, 32'h4);
        chkb(auxRegEn, 1'b1);
        cmpIn.auxAboveFail <= 1'b0;
        cyc(100);
        cmpIn.auxAboveFail <= 1'b1;
        chkb(auxRegEn, 1'b1);
        stchk(6'h02);
        cmpIn.auxAboveFail <= 1'b0;
        cyc(130);
        chkb(auxRegEn, 1'b0);
        cmpIn.auxAboveFail <= 1'b1;
        cyc(4);
        chkb(auxRegEn, 1'b0);
        stchk(6'h06);
        cyc(2);
        chkb(auxRegEn, 1'b1);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h4);
        cmpIn.xcvrSupplyLow <= 1'b1;
        cyc(4);
        chkb(xcvrEn, 1'b0);
        stchk(6'h30);
        cmpIn.xcvrSupplyLow <= 1'b0;
        cyc(4);
        chkb(xcvrEn, 1'b1);
        stchk(6'h10);
        cmpIn.thermalWarn <= 1'b1;
        cyc(4);
        chkb(loadDriversEn, 1'b0);
        chkb(auxRegEn, 1'b0);
        cmpIn.thermalWarn <= 1'b0;
        cyc(2);
        stchk(6'h08);
        chkb(loadDriversEn, 1'b1);
        // standby: load current decides the watchdog
        modeNormal <= 1'b0;
        modeStandby <= 1'b1;
        cyc(4);
        chkb(watchdogEn, 1'b1);
        cmpIn.loadCurrentLow <= 1'b1;
        cyc(4);
        chkb(watchdogEn, 1'b0);
        cmpIn.loadCurrentLow <= 1'b0;
        cyc(2);
        cmpIn.loadCurrentHigh <= 1'b1;
        cyc(4);
        chkb(watchdogEn, 1'b1);
        // cyclic-sense standby still watches the aux output
        cyclicSense <= 1'b1;
        cmpIn.auxAboveFail <= 1'b0;
        cyc(90);
        cmpIn.auxAboveFail <= 1'b1;
        cyc(4);
        chkb(auxRegEn, 1'b1);
        stchk(6'h02);
        cyclicSense <= 1'b0;
        modeNormal <= 1'b1;
        modeStandby <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            cmpIn.thermalShut <= 1'b1;
            cyc(4);
            chkb(mainRegEn, 1'b0);
            cmpIn.thermalShut <= 1'b0;
            cyc(44);
            chkb(mainRegEn, 1'b0);
            cyc(12);
            chkb(mainRegEn, k < 2);
            chkb(forceSleep, k == 2);
        end
        // restart into a shorted main output
        cmpIn.mainAboveFail <= 1'b0;
        cyc(3);
        wakeUp <= 1'b1;
        cyc(1);
        wakeUp <= 1'b0;
        cyc(4);
        chkb(forceSleep, 1'b0);
        cyc(45);
        chkb(forceSleep, 1'b1);
        apb(1'b0, STATUS_OFS, 32'h0);
        chkb(rd[ST_MAIN_FAIL], 1'b1);
        final_report();
    end
endmodule
